/* File: pal_defs.vh */
`ifndef PAL_DEFS_VH
`define PAL_DEFS_VH

// data path widths
`define BYTE_W          8
`define PTR_W           8
`define COLOR_W         24
`define PAL_DEPTH       256

// command select codes {cmd_select_high, cmd_select_low}
`define CMD_ADDR_A      2'h0
`define CMD_PALETTE     2'h1
`define CMD_ADDR_B      2'h2
`define CMD_OVERLAY     2'h3

// color phase codes {color_phase_bit1, color_phase_bit0}
`define PHASE_RED       2'h0
`define PHASE_GREEN     2'h1
`define PHASE_BLUE      2'h2

// overlay decode of pointer low bits and of overlay selects
`define OVL_RESERVED    2'h0
`define OVL_PALETTE     2'h0

// reset values
`define PTR_RESET       8'h00
`define OVL_RESET       24'h000000
`define BYTE_RESET      8'h00

// video word layout {sync_n, blank_n, red, green, blue}
`define WORD_W          26
`define WORD_SYNC_BIT   25
`define WORD_BLANK_BIT  24
`define RED_MSB         23
`define RED_LSB         16
`define GREEN_MSB       15
`define GREEN_LSB       8
`define BLUE_MSB        7
`define BLUE_LSB        0

// buffer depth and synchroniser widths
`define FIFO_DEPTH      2
`define HOST_SYNC_W     13
`define PIX_SYNC_W      13

`endif

/* File: sync_2ff.v */
`timescale 1ns/1ns
// two-stage synchroniser for asynchronous pin levels
module sync_2ff #(
  parameter W = 1
) (
  input  wire         clk_i,
  input  wire         rst_n_i,
  input  wire [W-1:0] d_i,
  input  wire [W-1:0] init_i,
  output reg  [W-1:0] q_o
);

  reg [W-1:0] meta_reg;
  reg [W-1:0] hold_reg;

  // flops keep the level relative to idle, so reset shows the idle level
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_reg <= {W{1'b0}};
      hold_reg <= {W{1'b0}};
    end else begin
      meta_reg <= d_i ^ init_i;
      hold_reg <= meta_reg; // first stage feeds only the second
    end
  end

  // undo the idle offset, no false strobe after reset
  always @* begin
    q_o = hold_reg ^ init_i;
  end

endmodule

/* File: video_fifo2.v */
`timescale 1ns/1ns
`include "pal_defs.vh"
// two-entry buffer with valid/ready on both sides
module video_fifo2 (
  input  wire                clk_i,
  input  wire                rst_n_i,
  input  wire                in_valid_i,
  input  wire [`WORD_W-1:0]  in_data_i,
  output wire                in_ready_o,
  output wire                out_valid_o,
  output wire [`WORD_W-1:0]  out_data_o,
  input  wire                out_ready_i
);

  reg [`WORD_W-1:0] entry_reg [0:`FIFO_DEPTH-1];
  reg               wr_ptr_reg;
  reg               rd_ptr_reg;
  reg [1:0]         count_reg;
  wire              push;
  wire              pop;

  // honest full and empty
  assign in_ready_o  = (count_reg != 2'h2);
  assign out_valid_o = (count_reg != 2'h0);
  assign out_data_o  = entry_reg[rd_ptr_reg];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  // entry storage, no reset needed
  always @(posedge clk_i) begin
    if (push) begin
      entry_reg[wr_ptr_reg] <= in_data_i;
    end
  end

  // pointers and fill count
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg  <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr_reg <= ~wr_ptr_reg;
      end
      if (pop) begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 2'h1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 2'h1;
      end
    end
  end

endmodule

/* File: color_palette_port.v */
`timescale 1ns/1ns
`include "pal_defs.vh"
// Functional notes
// - both low or high-low: pointer; low-high: palette; both: overlay
// - 8-bit pointer addresses palette and overlays, bit 0 from data line 0
// - red, green, blue writes; blue write stores the 24-bit word
// - pointer advances by one after the blue write
// - three reads return red, green, blue; pointer advances after blue read
// - chip select low forces all colors to black
// - pointer wraps to zero after blue access at last location
// - overlay accesses decode only the two low pointer bits
// - hidden 2-bit phase counts modulo three on each data access
// - pointer write clears the phase; pointer read keeps it
// - phase is never visible or writable; only 8 pointer bits are
// - overlay low bits 00 reserved; 01, 10, 11 pick colors one to three
// - with chip select high the latched pixel picks the 24-bit output
// - overlay select 00 uses palette, 01 color one, 10 color two
// - pixel index, overlay selects, sync and blank latched each rising edge; the code latches only while PIX_READY_O is high
// - latched blank low drives blanking level and ignores pixel inputs
// - latched sync low turns sync current off; never overrides colors
// - pixel line 0 and overlay select low are least significant bits
// - processor port runs without reference to the pixel clock
// - write needs select and strobe low; data taken at first rising edge
// - read with select and strobe low drives the addressed byte
module color_palette_port (
  input  wire         MCLK_I,
  input  wire         RESET_N_I,
  input  wire         CS_N_I,
  input  wire         RD_N_I,
  input  wire         WR_N_I,
  input  wire         CMD_SELECT_LOW_I,
  input  wire         CMD_SELECT_HIGH_I,
  input  wire [7:0]   HOST_DATA_BUS_I,
  output reg  [7:0]   HOST_DATA_BUS_O,
  output reg          HOST_DATA_BUS_OE_O,
  input  wire [7:0]   PIXEL_INDEX_I,
  input  wire         OVERLAY_SEL_LOW_I,
  input  wire         OVERLAY_SEL_HIGH_I,
  input  wire         PIX_SYNC_N_I,
  input  wire         PIX_BLANK_N_I,
  input  wire         PIX_VALID_I,
  output wire         PIX_READY_O,
  output reg  [7:0]   RED_CURRENT_OUT_O,
  output reg  [7:0]   GREEN_CURRENT_OUT_O,
  output reg  [7:0]   BLUE_CURRENT_OUT_O,
  output reg          BLANK_LEVEL_O,
  output reg          SYNC_CURRENT_OUT_O,
  output reg          VIDEO_VALID_O,
  input  wire         VIDEO_READY_I
);

  // reset release
  reg                   rst_meta_reg;
  reg                   rst_n_reg;

  // synchronised processor pins
  wire [`HOST_SYNC_W-1:0] host_sync;
  wire                  cs_n_s;
  wire                  rd_n_s;
  wire                  wr_n_s;
  wire [1:0]            cmd_s;
  wire [7:0]            hdata_s;

  // synchronised pixel pins
  wire [`PIX_SYNC_W-1:0] pix_sync;

  // processor side state
  reg  [7:0]            pointer_reg;
  reg  [7:0]            pointer_next;
  reg  [1:0]            phase_reg;
  reg  [1:0]            phase_next;
  reg  [7:0]            red_hold_reg;
  reg  [7:0]            red_hold_next;
  reg  [7:0]            green_hold_reg;
  reg  [7:0]            green_hold_next;
  reg  [7:0]            wdata_reg;
  reg  [1:0]            cmd_reg;
  reg                   wr_act_reg;
  reg                   rd_act_reg;
  reg                   pal_we;
  reg                   ovl_we;
  wire                  wr_act;
  wire                  rd_act;
  wire                  wr_end;
  wire                  rd_end;
  wire                  tgt_addr;
  wire                  tgt_pal;
  wire                  tgt_ovl;
  wire                  cur_addr;
  wire                  cur_pal;
  wire [23:0]           store_word;
  reg  [23:0]           read_word;
  reg  [7:0]            read_byte;

  // color storage
  reg  [`COLOR_W-1:0]   palette_mem [0:`PAL_DEPTH-1];
  wire [4*`COLOR_W-1:0] ovl_flat;

  // pixel latch stage
  reg                   lat_valid_reg;
  reg  [7:0]            lat_index_reg;
  reg  [1:0]            lat_ovl_reg;
  reg                   lat_sync_n_reg;
  reg                   lat_blank_n_reg;
  wire                  lat_take;
  reg  [23:0]           look_color;
  wire [`WORD_W-1:0]    look_word;

  // buffer handshake
  wire                  fifo_in_ready;
  wire                  fifo_out_valid;
  wire [`WORD_W-1:0]    fifo_out_data;
  wire                  fifo_out_ready;

  // asynchronous assert, two-flop release
  always @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg    <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg    <= rst_meta_reg;
    end
  end

  // processor pins cross into the clock domain; idle strobes sit high
  sync_2ff #(
    .W (`HOST_SYNC_W)
  ) u_host_sync (
    .clk_i   (MCLK_I),
    .rst_n_i (rst_n_reg),
    .d_i     ({CS_N_I, RD_N_I, WR_N_I, CMD_SELECT_HIGH_I,
               CMD_SELECT_LOW_I, HOST_DATA_BUS_I}),
    .init_i  (13'h1c00),
    .q_o     (host_sync)
  );

  assign cs_n_s  = host_sync[12];
  assign rd_n_s  = host_sync[11];
  assign wr_n_s  = host_sync[10];
  assign cmd_s   = host_sync[9:8];
  assign hdata_s = host_sync[7:0]; // bit 0 is data line 0

  // pixel pins cross in; idle sync and blank sit high
  sync_2ff #(
    .W (`PIX_SYNC_W)
  ) u_pix_sync (
    .clk_i   (MCLK_I),
    .rst_n_i (rst_n_reg),
    .d_i     ({PIX_VALID_I, PIX_SYNC_N_I, PIX_BLANK_N_I,
               OVERLAY_SEL_HIGH_I, OVERLAY_SEL_LOW_I, PIXEL_INDEX_I}),
    .init_i  (13'h0c00),
    .q_o     (pix_sync)
  );

  // strobe activity and end-of-cycle events
  assign wr_act = ~cs_n_s & ~wr_n_s;
  assign rd_act = ~cs_n_s & ~rd_n_s;
  assign wr_end = wr_act_reg & ~wr_act; // first rising edge of either
  assign rd_end = rd_act_reg & ~rd_act & ~wr_end;

  // target decode of the command selects
  assign tgt_pal  = (cmd_reg == `CMD_PALETTE);
  assign tgt_ovl  = (cmd_reg == `CMD_OVERLAY);
  assign tgt_addr = ~tgt_pal & ~tgt_ovl;
  assign cur_pal  = (cmd_s == `CMD_PALETTE);
  assign cur_addr = (cmd_s == `CMD_ADDR_A) | (cmd_s == `CMD_ADDR_B);

  // blue write concatenates the held bytes
  assign store_word = {red_hold_reg, green_hold_reg, wdata_reg};

  // pointer, phase and byte sequencing
  always @* begin
    pointer_next    = pointer_reg;
    phase_next      = phase_reg;
    red_hold_next   = red_hold_reg;
    green_hold_next = green_hold_reg;
    pal_we          = 1'b0;
    ovl_we          = 1'b0;
    if (wr_end) begin
      if (tgt_addr) begin
        pointer_next = wdata_reg;
        phase_next   = `PHASE_RED;
      end else begin
        case (phase_reg)
          `PHASE_RED: begin
            red_hold_next = wdata_reg;
            phase_next    = `PHASE_GREEN;
          end
          `PHASE_GREEN: begin
            green_hold_next = wdata_reg;
            phase_next      = `PHASE_BLUE;
          end
          `PHASE_BLUE: begin
            pal_we       = tgt_pal;
            ovl_we       = tgt_ovl &
                           (pointer_reg[1:0] != `OVL_RESERVED);
            pointer_next = pointer_reg + 8'h01; // wraps ff to 00
            phase_next   = `PHASE_RED;
          end
          default: begin
            phase_next = `PHASE_RED;
          end
        endcase
      end
    end else if (rd_end && !tgt_addr) begin
      // pointer reads leave the phase alone
      case (phase_reg)
        `PHASE_RED: begin
          phase_next = `PHASE_GREEN;
        end
        `PHASE_GREEN: begin
          phase_next = `PHASE_BLUE;
        end
        `PHASE_BLUE: begin
          pointer_next = pointer_reg + 8'h01;
          phase_next   = `PHASE_RED;
        end
        default: begin
          phase_next = `PHASE_RED;
        end
      endcase
    end
  end

  // processor side registers
  always @(posedge MCLK_I or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      pointer_reg    <= `PTR_RESET;
      phase_reg      <= `PHASE_RED;
      red_hold_reg   <= `BYTE_RESET;
      green_hold_reg <= `BYTE_RESET;
      wdata_reg      <= `BYTE_RESET;
      cmd_reg        <= `CMD_ADDR_A;
      wr_act_reg     <= 1'b0;
      rd_act_reg     <= 1'b0;
    end else begin
      pointer_reg    <= pointer_next;
      phase_reg      <= phase_next;
      red_hold_reg   <= red_hold_next;
      green_hold_reg <= green_hold_next;
      wr_act_reg     <= wr_act;
      rd_act_reg     <= rd_act;
      if (wr_act) begin
        wdata_reg <= hdata_s; // last byte before the strobe rises
      end
      if (wr_act || rd_act) begin
        cmd_reg <= cmd_s;
      end
    end
  end

  // palette write port
  always @(posedge MCLK_I) begin
    if (pal_we) begin
      palette_mem[pointer_reg] <= store_word;
    end
  end

  // overlay colors, entry 0 is the reserved slot
  genvar k;
  generate
    for (k = 0; k < 4; k = k + 1) begin : g_ovl
      if (k == 0) begin : g_rsv
        assign ovl_flat[`COLOR_W-1:0] = `OVL_RESET;
      end else begin : g_col
        reg [`COLOR_W-1:0] color_reg;
        always @(posedge MCLK_I or negedge rst_n_reg) begin
          if (!rst_n_reg) begin
            color_reg <= `OVL_RESET;
          end else if (ovl_we && pointer_reg[1:0] == k) begin
            color_reg <= store_word; // slot picked by pointer low bits only
          end
        end
        assign ovl_flat[k*`COLOR_W +: `COLOR_W] = color_reg;
      end
    end
  endgenerate

  // addressed word and byte for reads; phase itself never shows
  always @* begin
    if (cur_pal) begin
      read_word = palette_mem[pointer_reg];
    end else begin
      read_word = ovl_flat[pointer_reg[1:0]*`COLOR_W +: `COLOR_W];
    end
    case (phase_reg)
      `PHASE_RED:   read_byte = read_word[23:16];
      `PHASE_GREEN: read_byte = read_word[15:8];
      `PHASE_BLUE:  read_byte = read_word[7:0];
      default:      read_byte = `BYTE_RESET;
    endcase
    if (cur_addr) begin
      read_byte = pointer_reg;
    end
  end

  // data bus drive during a read
  always @(posedge MCLK_I or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      HOST_DATA_BUS_O    <= `BYTE_RESET;
      HOST_DATA_BUS_OE_O <= 1'b0;
    end else begin
      HOST_DATA_BUS_OE_O <= rd_act & ~wr_act;
      if (rd_act) begin
        HOST_DATA_BUS_O <= read_byte;
      end
    end
  end

  // latch stage accepts when empty or when the buffer takes its word
  assign lat_take    = ~lat_valid_reg | fifo_in_ready;
  assign PIX_READY_O = lat_take;

  always @(posedge MCLK_I or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      lat_valid_reg   <= 1'b0;
      lat_index_reg   <= 8'h00;
      lat_ovl_reg     <= `OVL_PALETTE;
      lat_sync_n_reg  <= 1'b1;
      lat_blank_n_reg <= 1'b1;
    end else if (lat_take) begin
      lat_valid_reg   <= pix_sync[12];
      lat_sync_n_reg  <= pix_sync[11];
      lat_blank_n_reg <= pix_sync[10];
      lat_ovl_reg     <= pix_sync[9:8]; // select low is bit 0
      lat_index_reg   <= pix_sync[7:0]; // line 0 is bit 0
    end
  end

  // color lookup with blank and chip select overrides
  always @* begin
    if (!lat_blank_n_reg) begin
      look_color = `OVL_RESET; // blanking level
    end else if (!cs_n_s) begin
      look_color = `OVL_RESET; // processor owns the port: black
    end else if (lat_ovl_reg == `OVL_PALETTE) begin
      look_color = palette_mem[lat_index_reg];
    end else begin
      look_color = ovl_flat[lat_ovl_reg*`COLOR_W +: `COLOR_W];
    end
  end

  // sync only steers its own current
  assign look_word = {lat_sync_n_reg, lat_blank_n_reg, look_color};

  video_fifo2 u_fifo (
    .clk_i       (MCLK_I),
    .rst_n_i     (rst_n_reg),
    .in_valid_i  (lat_valid_reg),
    .in_data_i   (look_word),
    .in_ready_o  (fifo_in_ready),
    .out_valid_o (fifo_out_valid),
    .out_data_o  (fifo_out_data),
    .out_ready_i (fifo_out_ready)
  );

  // registered converter outputs
  assign fifo_out_ready = ~VIDEO_VALID_O | VIDEO_READY_I;

  always @(posedge MCLK_I or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      VIDEO_VALID_O       <= 1'b0;
      RED_CURRENT_OUT_O   <= `BYTE_RESET;
      GREEN_CURRENT_OUT_O <= `BYTE_RESET;
      BLUE_CURRENT_OUT_O  <= `BYTE_RESET;
      BLANK_LEVEL_O       <= 1'b1;
      SYNC_CURRENT_OUT_O  <= 1'b1;
    end else if (fifo_out_ready) begin
      VIDEO_VALID_O <= fifo_out_valid;
      if (fifo_out_valid) begin
        RED_CURRENT_OUT_O   <= fifo_out_data[`RED_MSB:`RED_LSB];
        GREEN_CURRENT_OUT_O <= fifo_out_data[`GREEN_MSB:`GREEN_LSB];
        BLUE_CURRENT_OUT_O  <= fifo_out_data[`BLUE_MSB:`BLUE_LSB];
        BLANK_LEVEL_O       <= ~fifo_out_data[`WORD_BLANK_BIT];
        SYNC_CURRENT_OUT_O  <= fifo_out_data[`WORD_SYNC_BIT];
      end
    end
  end

endmodule

/* File: pix_source_model.sv */
`timescale 1ns/1ns
// frame buffer side: one pixel word per call, valid for one clock
module pix_source_model (
  input  wire       clk_i,
  output reg  [7:0] index_o,
  output reg  [1:0] ovl_o,
  output reg        sync_n_o,
  output reg        blank_n_o,
  output reg        valid_o
);
  // idle lines at time zero
  initial begin
    index_o = 8'h00;
    ovl_o = 2'h0;
    sync_n_o = 1'b1;
    blank_n_o = 1'b1;
    valid_o = 1'b0;
  end

  // present a word, then scramble the released data lines
  task send(input [7:0] idx, input [1:0] ovl, input snc, input blk);
    @(posedge clk_i);
    #1;
    index_o = idx;
    ovl_o = ovl;
    sync_n_o = snc | blk; // sync only inside blanking
    blank_n_o = blk;
    valid_o = 1'b1;
    @(posedge clk_i);
    #1;
    valid_o = 1'b0;
    index_o = ~idx;
    ovl_o = ~ovl;
  endtask
endmodule

/* File: color_palette_port_chk.sv */
`timescale 1ns/1ns
module color_palette_port_chk (
  input wire       MCLK_I,
  input wire       RESET_N_I,
  input wire       CS_N_I,
  input wire       RD_N_I,
  input wire       WR_N_I,
  input wire       PIX_VALID_I,
  input wire       PIX_READY_O,
  input wire       HOST_DATA_BUS_OE_O,
  input wire [7:0] RED_CURRENT_OUT_O,
  input wire [7:0] GREEN_CURRENT_OUT_O,
  input wire [7:0] BLUE_CURRENT_OUT_O,
  input wire       BLANK_LEVEL_O,
  input wire       SYNC_CURRENT_OUT_O,
  input wire       VIDEO_VALID_O,
  input wire       VIDEO_READY_I
);
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RESET_N_I);

  a_oe_on_read: assert property (
    (!CS_N_I && !RD_N_I && WR_N_I) [*5] |-> HOST_DATA_BUS_OE_O)
    else $error("read data not driven");
  a_oe_off_idle: assert property (
    (CS_N_I || RD_N_I) [*5] |-> !HOST_DATA_BUS_OE_O)
    else $error("bus driven outside a read");
  a_oe_not_write: assert property (
    (!WR_N_I) [*4] |-> !HOST_DATA_BUS_OE_O)
    else $error("bus driven during a write");
  a_blank_black: assert property (
    VIDEO_VALID_O && BLANK_LEVEL_O |->
    {RED_CURRENT_OUT_O, GREEN_CURRENT_OUT_O, BLUE_CURRENT_OUT_O} == 24'h0)
    else $error("blanked word carries color");
  a_sync_in_blank: assert property (
    VIDEO_VALID_O && !SYNC_CURRENT_OUT_O |-> BLANK_LEVEL_O)
    else $error("sync off outside blanking");
  a_stall_hold: assert property (
    VIDEO_VALID_O && !VIDEO_READY_I |=> VIDEO_VALID_O &&
    $stable({RED_CURRENT_OUT_O, GREEN_CURRENT_OUT_O, BLUE_CURRENT_OUT_O,
             BLANK_LEVEL_O, SYNC_CURRENT_OUT_O}))
    else $error("word changed while stalled");
  a_pix_latency: assert property (
    $rose(PIX_VALID_I) && PIX_READY_O && !VIDEO_VALID_O |->
    ##[2:5] VIDEO_VALID_O)
    else $error("pixel word not delivered");
  a_ready_empty: assert property (
    !VIDEO_VALID_O |-> PIX_READY_O)
    else $error("refused with empty buffer");
endmodule

bind color_palette_port color_palette_port_chk chk_u (
  .MCLK_I(MCLK_I), .RESET_N_I(RESET_N_I), .CS_N_I(CS_N_I),
  .RD_N_I(RD_N_I), .WR_N_I(WR_N_I), .PIX_VALID_I(PIX_VALID_I),
  .PIX_READY_O(PIX_READY_O), .HOST_DATA_BUS_OE_O(HOST_DATA_BUS_OE_O),
  .RED_CURRENT_OUT_O(RED_CURRENT_OUT_O),
  .GREEN_CURRENT_OUT_O(GREEN_CURRENT_OUT_O),
  .BLUE_CURRENT_OUT_O(BLUE_CURRENT_OUT_O), .BLANK_LEVEL_O(BLANK_LEVEL_O),
  .SYNC_CURRENT_OUT_O(SYNC_CURRENT_OUT_O), .VIDEO_VALID_O(VIDEO_VALID_O),
  .VIDEO_READY_I(VIDEO_READY_I)
);

/* File: color_palette_port_tb.sv */
`timescale 1ns/1ns
module color_palette_port_tb;
  reg         mclk;
  reg         rst_n;
  reg         cs_n;
  reg         rd_n;
  reg         wr_n;
  reg  [1:0]  cmd;
  reg  [7:0]  bus_drv;
  reg         vrdy;
  reg         oe_seen;
  wire [7:0]  bus_o;
  wire        oe;
  wire [7:0]  pidx;
  wire [1:0]  povl;
  wire        psync;
  wire        pblank;
  wire        pvalid;
  wire        prdy;
  wire [7:0]  red;
  wire [7:0]  grn;
  wire [7:0]  blu;
  wire        blank_lvl;
  wire        sync_on;
  wire        vvalid;
  wire [7:0]  bus_in;
  reg  [25:0] vq[$];
  reg  [7:0]  hq[$];
  reg  [23:0] pal[0:255];
  reg  [23:0] ovr[0:3];
  reg  [23:0] c;
  reg  [7:0]  p;
  integer     bad_count;
  integer     check_count;
  integer     seed;
  integer     i;
  integer     n;

  // shared data bus, device wins while driving
  assign bus_in = oe ? bus_o : bus_drv;

  color_palette_port dut_u (
    .MCLK_I(mclk), .RESET_N_I(rst_n), .CS_N_I(cs_n), .RD_N_I(rd_n),
    .WR_N_I(wr_n), .CMD_SELECT_LOW_I(cmd[0]), .CMD_SELECT_HIGH_I(cmd[1]),
    .HOST_DATA_BUS_I(bus_in), .HOST_DATA_BUS_O(bus_o),
    .HOST_DATA_BUS_OE_O(oe), .PIXEL_INDEX_I(pidx),
    .OVERLAY_SEL_LOW_I(povl[0]), .OVERLAY_SEL_HIGH_I(povl[1]),
    .PIX_SYNC_N_I(psync), .PIX_BLANK_N_I(pblank), .PIX_VALID_I(pvalid),
    .PIX_READY_O(prdy), .RED_CURRENT_OUT_O(red),
    .GREEN_CURRENT_OUT_O(grn), .BLUE_CURRENT_OUT_O(blu),
    .BLANK_LEVEL_O(blank_lvl), .SYNC_CURRENT_OUT_O(sync_on),
    .VIDEO_VALID_O(vvalid), .VIDEO_READY_I(vrdy)
  );

  pix_source_model src_u (
    .clk_i(mclk), .index_o(pidx), .ovl_o(povl), .sync_n_o(psync),
    .blank_n_o(pblank), .valid_o(pvalid)
  );

  // clock
  always #5 mclk = ~mclk;

  task check(input [25:0] seen, input [25:0] wanted);
    check_count = check_count + 1;
    if (seen !== wanted) begin
      bad_count = bad_count + 1;
      $display("CHECK FAILED %0t: saw %h want %h", $time, seen, wanted);
    end
  endtask

  task close_out;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // expected output word {sync flag, blank flag, rgb}
  function [25:0] want(input [7:0] ix, input [1:0] ol, input s, input b,
                       input cs);
    reg [23:0] rgb;
    begin
      rgb = (ol == 2'h0) ? pal[ix] : ovr[ol];
      if (!b || !cs)
        rgb = 24'h000000;
      want = {s | b, ~b, rgb};
    end
  endfunction

  // write strobes held 4 clocks, read strobes 5, read never overlaps write
  task host_wr(input [1:0] cm, input [7:0] d);
    cmd = cm;
    bus_drv = d;
    cs_n = 1'b0;
    wr_n = 1'b0;
    repeat (4) @(posedge mclk);
    #1;
    cs_n = 1'b1;
    wr_n = 1'b1;
    bus_drv = ~d;
    repeat (4) @(posedge mclk);
    #1;
  endtask

  task host_rd(input [1:0] cm, input [7:0] d);
    cmd = cm;
    hq.push_back(d);
    cs_n = 1'b0;
    rd_n = 1'b0;
    repeat (5) @(posedge mclk);
    #1;
    cs_n = 1'b1;
    rd_n = 1'b1;
    repeat (5) @(posedge mclk);
    #1;
  endtask

  task wr3(input [1:0] cm, input [23:0] v);
    host_wr(cm, v[23:16]);
    host_wr(cm, v[15:8]);
    host_wr(cm, v[7:0]);
  endtask

  task rd3(input [1:0] cm, input [23:0] v);
    host_rd(cm, v[23:16]);
    host_rd(cm, v[15:8]);
    host_rd(cm, v[7:0]);
  endtask

  task pix(input [7:0] ix, input [1:0] ol, input s, input b);
    vq.push_back(want(ix, ol, s | b, b, cs_n));
    src_u.send(ix, ol, s, b);
    repeat (3) @(posedge mclk);
    #1;
  endtask

  // monitor: oldest note against each delivered result
  always @(posedge mclk) begin
    #2;
    if (oe && !oe_seen)
      check({18'h0, bus_o}, hq.size() ? {18'h0, hq.pop_front()} : 'x);
    oe_seen = oe;
    if (vvalid && vrdy)
      check({sync_on, blank_lvl, red, grn, blu},
            vq.size() ? vq.pop_front() : 'x);
  end

  // watchdog, tests need about 700 clocks
  initial begin
    #200000;
    bad_count = bad_count + 1;
    close_out;
  end

  initial begin
    seed = 42;
    bad_count = 0;
    check_count = 0;
    mclk = 1'b0;
    rst_n = 1'b0;
    {cs_n, rd_n, wr_n, vrdy, oe_seen} = 5'h1e;
    cmd = 2'h0;
    bus_drv = 8'h00;
    for (i = 0; i < 4; i = i + 1)
      ovr[i] = 24'h000000;
    repeat (16) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    repeat (6) @(posedge mclk);
    #1;
    // wrap across the last palette entry
    host_wr(2'h2, 8'hfe);
    for (i = 0; i < 3; i = i + 1) begin
      c = 24'($random(seed));
      p = 8'hfe + i[7:0];
      pal[p] = c;
      wr3(2'h1, c);
    end
    host_rd(2'h0, 8'h01);
    host_wr(2'h0, 8'hfe);
    for (i = 0; i < 3; i = i + 1) begin
      p = 8'hfe + i[7:0];
      rd3(2'h1, pal[p]);
    end
    host_rd(2'h2, 8'h01);
    $display("test palette done");
    // half-written color dropped, pointer read keeps the phase
    host_wr(2'h0, 8'h10);
    host_wr(2'h1, 8'h77);
    host_wr(2'h0, 8'h10);
    c = 24'($random(seed));
    pal[8'h10] = c;
    wr3(2'h1, c);
    host_wr(2'h0, 8'h10);
    host_rd(2'h1, c[23:16]);
    host_rd(2'h1, c[15:8]);
    host_rd(2'h0, 8'h10);
    host_rd(2'h1, c[7:0]);
    host_rd(2'h0, 8'h11);
    $display("test phase done");
    // overlay slots under random upper pointer bits
    for (i = 0; i < 4; i = i + 1) begin
      c = 24'($random(seed));
      if (i > 0)
        ovr[i] = c;
      p = 8'($random(seed));
      host_wr(2'h0, {p[7:2], i[1:0]});
      wr3(2'h3, c);
      p = 8'($random(seed));
      host_wr(2'h0, {p[7:2], i[1:0]});
      rd3(2'h3, ovr[i]);
    end
    host_rd(2'h0, {p[7:2], 2'h3} + 8'h01);
    $display("test overlay done");
    // lookups, blanking, sync, black while chip select is low
    for (i = 0; i < 4; i = i + 1)
      pix(i ? 8'($random(seed)) : 8'hff, i[1:0], 1'b1, 1'b1);
    pix(8'h10, 2'h1, 1'b1, 1'b0);
    pix(8'h10, 2'h0, 1'b0, 1'b0);
    cs_n = 1'b0;
    repeat (4) @(posedge mclk);
    #1;
    pix(8'hff, 2'h0, 1'b1, 1'b1);
    cs_n = 1'b1;
    $display("test video done");
    // sink stalls: fill until refused, drain with random stalls
    vrdy = 1'b0;
    n = 0;
    while (prdy === 1'b1 && n < 6) begin
      pix(n[0] ? 8'hff : 8'hfe, 2'h0, 1'b1, 1'b1);
      n = n + 1;
    end
    check({25'h0, prdy}, 26'h0);
    for (i = 0; i < 12; i = i + 1) begin
      vrdy = 1'($random(seed));
      @(posedge mclk);
      #1;
    end
    vrdy = 1'b1;
    repeat (10) @(posedge mclk);
    check(26'(vq.size() + hq.size()), 26'h0);
    $display("test buffer done");
    close_out;
  end
endmodule
